/* pkg/hbi_pkg.sv */
// Package of constants and types for the host bus interface unit
package hbi_pkg;
   // ------------------------------------------------------------
   // Address and lane geometry
   // ------------------------------------------------------------
   localparam int ADDR_MSB    = 15;          // Top address bit
   localparam int DEC_LSB     = 4;           // Lowest decoded bit
   localparam int LATCH_LSB   = 1;           // Lowest latched bit
   localparam int LANES       = 4;           // Byte lanes
   localparam int DEC_W       = ADDR_MSB - DEC_LSB + 1;
   localparam int ADDR_W      = ADDR_MSB - LATCH_LSB + 1;
   localparam int REG_W       = DEC_LSB - LATCH_LSB; // Register index bits

   // Register index of the queue data register inside the window
   localparam logic [REG_W-1:0] DATA_REG_IDX = 3'h4;
   // Default base address for the local decoder
   localparam logic [DEC_W-1:0] BASE_DEFAULT = 12'h030;

   // ------------------------------------------------------------
   // Byte-lane patterns, active low, bit i is lane i
   // ------------------------------------------------------------
   localparam logic [LANES-1:0] LANES_ALL   = 4'h0;
   localparam logic [LANES-1:0] LANES_LOW   = 4'hc;
   localparam logic [LANES-1:0] LANES_HIGH  = 4'h3;
   localparam logic [LANES-1:0] LANES_B0    = 4'he;
   localparam logic [LANES-1:0] LANES_B1    = 4'hd;
   localparam logic [LANES-1:0] LANES_B2    = 4'hb;
   localparam logic [LANES-1:0] LANES_B3    = 4'h7;

   // Width of an access
   typedef enum logic [2:0] {
      HBI_W_NONE, HBI_W_32, HBI_W_LO16, HBI_W_HI16,
      HBI_W_B0, HBI_W_B1, HBI_W_B2, HBI_W_B3
   } hbi_width_type;

   // Cycles the device holds its ready high before answering
   localparam int WAIT_CYCLES = 2;
endpackage

/* pkg/hbi_addr_if.sv */
// Interface carrying the captured address between address latch and decoder
`timescale 1ns/1ps
interface hbi_addr_if;
   logic [hbi_pkg::ADDR_W-1:0] addr;     // Address bits 15..1
   logic                       qual;     // Address qualifier
   logic [hbi_pkg::LANES-1:0]  lanes_n;  // Lane enables, active low
   modport src  (output addr, output qual, output lanes_n);
   modport sink (input addr, input qual, input lanes_n);
endinterface

/* rtl/hbi_addr_latch.sv */
// Transparent address latch closed by the address strobe rising edge
`timescale 1ns/1ps
module hbi_addr_latch (
   // Clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       rst_n,
   // Raw host address group
   input  wire logic [hbi_pkg::ADDR_W-1:0] addr_in,
   input  wire logic                       address_qualifier,
   input  wire logic [hbi_pkg::LANES-1:0]  lanes_n_in,
   input  wire logic                       address_latch_strobe,
   // Captured address to the core
   hbi_addr_if.src                         outp
);
   // ------------------------------------------------------------
   // Held copy
   // ------------------------------------------------------------
   logic [hbi_pkg::ADDR_W-1:0] held_addr;   // Address at last strobe rise
   logic                       held_qual;   // Qualifier at last strobe rise
   logic [hbi_pkg::LANES-1:0]  held_lanes;  // Lanes at last strobe rise
   logic                       strobe_q;    // Strobe one clock ago

   // Capture on every clock while the strobe is low
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         held_addr  <= '0;
         held_qual  <= 1'b0;
         held_lanes <= '1;
         strobe_q   <= 1'b1;
      end else begin
         strobe_q <= address_latch_strobe;
         if (!address_latch_strobe) begin // Transparent while low
            held_addr  <= addr_in;
            held_qual  <= address_qualifier;
            held_lanes <= lanes_n_in;
         end
      end
   end

   // Low strobe passes live values; high strobe holds the capture.
   // A strobe tied low therefore gives plain live decode.
   always_comb begin
      if (!address_latch_strobe) begin
         outp.addr    = addr_in;
         outp.qual    = address_qualifier;
         outp.lanes_n = lanes_n_in;
      end else begin
         outp.addr    = held_addr;
         outp.qual    = held_qual;
         outp.lanes_n = held_lanes;
      end
   end

   // Held value must match what stood just before the strobe rose
   a_latch_holds_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!strobe_q && address_latch_strobe) |-> held_addr == $past(addr_in))
      else $error("latched address differs from pre-edge address");
endmodule

/* rtl/hbi_bus_unit.sv */
// Host bus interface unit: decode, lane select, sync and async ready
//
// Summary of operation
// - Hit is registered decode of qualifier, address
// - Hit asserts when local decoder selects us and data select is high
// - Data select bypasses decode, forces 32-bit access
// - Data select ignores lanes, reaches only data
// - Flavour pin: low single cycles, high burst
// - Cycle strobe samples write/read; burst write strobe
// - Sync ready ends single cycle, waits burst
// - Async ready low inserts wait states
// - Strobe rise latches address, qualifier, lanes
// - Async interface does single transfers only
// - Decode bits 15..4 qualified by address enable
// - Write data captured on write strobe rise
// - Pulsed strobe latches address for decode
// - Lane enables choose 32, 16 or 8 bits
`timescale 1ns/1ps
module hbi_bus_unit #(
   parameter logic [hbi_pkg::DEC_W-1:0] BASE_ADDR = hbi_pkg::BASE_DEFAULT,
   parameter int                        DATA_W    = 32
) (
   // Clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       rst_n,
   // Address group
   input  wire logic [hbi_pkg::ADDR_W-1:0] addr_in,
   input  wire logic                       address_qualifier,
   input  wire logic                       lane0_enable,
   input  wire logic                       lane1_enable,
   input  wire logic                       lane2_enable,
   input  wire logic                       lane3_enable,
   input  wire logic                       address_latch_strobe,
   input  wire logic                       data_reg_select,
   // Synchronous transfer group
   input  wire logic                       sync_flavour_select,
   input  wire logic                       cycle_strobe,
   input  wire logic                       write_read_select,
   input  wire logic                       ready_return_in,
   // Asynchronous transfer group
   input  wire logic                       async_read_strobe,
   input  wire logic                       async_write_strobe,
   // Write data from host
   input  wire logic [DATA_W-1:0]          wdata_in,
   // Decode and ready outputs
   output logic                            local_hit_out,
   output logic                            sync_ready_out,
   output logic                            async_wait_out,
   // Captured access toward the register core
   output logic                            wr_pulse,
   output logic                            rd_pulse,
   output logic [hbi_pkg::REG_W-1:0]       reg_index,
   output logic                            data_reg_hit,
   output hbi_pkg::hbi_width_type          access_width,
   output logic [DATA_W-1:0]               wdata_out
);
   // ------------------------------------------------------------
   // Address capture
   // ------------------------------------------------------------
   hbi_addr_if cap ();   // Captured address group
   logic [hbi_pkg::LANES-1:0] lanes_raw;   // Lane enables, active low

   assign lanes_raw = {lane3_enable, lane2_enable, lane1_enable,
                       lane0_enable};

   hbi_addr_latch u_latch (
      .core_clk             (core_clk),
      .rst_n                (rst_n),
      .addr_in              (addr_in),
      .address_qualifier    (address_qualifier),
      .lanes_n_in           (lanes_raw),
      .address_latch_strobe (address_latch_strobe),
      .outp                 (cap)
   );

   // ------------------------------------------------------------
   // Decoding functions
   // ------------------------------------------------------------
   // Lane pattern to access width; unlisted patterns are no access
   function automatic hbi_pkg::hbi_width_type lane_width(
      input logic [hbi_pkg::LANES-1:0] l);
      case (l)
         hbi_pkg::LANES_ALL:  lane_width = hbi_pkg::HBI_W_32;
         hbi_pkg::LANES_LOW:  lane_width = hbi_pkg::HBI_W_LO16;
         hbi_pkg::LANES_HIGH: lane_width = hbi_pkg::HBI_W_HI16;
         hbi_pkg::LANES_B0:   lane_width = hbi_pkg::HBI_W_B0;
         hbi_pkg::LANES_B1:   lane_width = hbi_pkg::HBI_W_B1;
         hbi_pkg::LANES_B2:   lane_width = hbi_pkg::HBI_W_B2;
         hbi_pkg::LANES_B3:   lane_width = hbi_pkg::HBI_W_B3;
         default:             lane_width = hbi_pkg::HBI_W_NONE;
      endcase
   endfunction

   // Base compare of bits 15..4 qualified by the address enable
   function automatic logic base_match(
      input logic [hbi_pkg::ADDR_W-1:0] a, input logic q);
      base_match = q &&
         (a[hbi_pkg::ADDR_W-1:hbi_pkg::REG_W] == BASE_ADDR);
   endfunction

   // ------------------------------------------------------------
   // Combinational decode
   // ------------------------------------------------------------
   logic                   dec_hit;    // Local decoder match
   logic                   sel_any;    // Target selected either way
   hbi_pkg::hbi_width_type dec_width;  // Width of this access

   always_comb begin
      dec_hit = base_match(cap.addr, cap.qual);
      sel_any = dec_hit || !data_reg_select;
      if (!data_reg_select) begin
         dec_width = hbi_pkg::HBI_W_32;
      end else begin
         dec_width = lane_width(cap.lanes_n);
      end
   end

   // Hit output; registered because top outputs come from flops.
   // Costs one clock of latency against a purely gated decode.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         local_hit_out <= 1'b1;
      end else begin
         local_hit_out <= !(dec_hit && data_reg_select);
      end
   end

   // ------------------------------------------------------------
   // Asynchronous strobe edge detection
   // ------------------------------------------------------------
   logic rd_q;   // Read strobe one clock ago
   logic wr_q;   // Write strobe one clock ago
   logic async_active;  // Either async strobe low

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= 1'b1;
         wr_q <= 1'b1;
      end else begin
         rd_q <= async_read_strobe;
         wr_q <= async_write_strobe;
      end
   end

   assign async_active = !async_read_strobe || !async_write_strobe;

   // ------------------------------------------------------------
   // Synchronous cycle machine
   // ------------------------------------------------------------
   typedef enum {HBI_S_IDLE, HBI_S_WAIT, HBI_S_READY} hbi_state_type;
   hbi_state_type state;       // Sync cycle state
   hbi_state_type next_state;  // Next sync state
   logic [1:0]    wait_cnt;    // Wait-state counter
   logic          sync_wr;     // Direction sampled by cycle strobe
   logic          sync_start;  // Cycle begins this clock

   // Single mode starts on cycle strobe; burst on either bus strobe
   always_comb begin
      if (!sync_flavour_select) begin
         sync_start = !cycle_strobe && sel_any;
      end else begin
         sync_start = (!cycle_strobe || !write_read_select) && sel_any;
      end
      next_state = state;
      case (state)
         HBI_S_IDLE:  if (sync_start) next_state = HBI_S_WAIT;
         HBI_S_WAIT:  if (wait_cnt == 2'(hbi_pkg::WAIT_CYCLES - 1))
                         next_state = HBI_S_READY;
         HBI_S_READY: begin
            // Single: hold until ready-return; burst: host waits
            if (!sync_flavour_select) begin
               if (!ready_return_in) next_state = HBI_S_IDLE;
            end else if (ready_return_in && !sync_start) begin
               next_state = HBI_S_IDLE;
            end
         end
         default:     next_state = HBI_S_IDLE;
      endcase
   end

   // State and sampled direction, on bus clock rising edges
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= HBI_S_IDLE;
         wait_cnt <= 2'h0;
         sync_wr  <= 1'b0;
      end else begin
         state <= next_state;
         if (state == HBI_S_IDLE && sync_start) begin
            wait_cnt <= 2'h0;
            // Single: high means write; burst: write strobe low
            sync_wr  <= sync_flavour_select ? !cycle_strobe
                                            : write_read_select;
         end else if (state == HBI_S_WAIT) begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end

   // Ready low while answering; high (wait) otherwise
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_ready_out <= 1'b1;
      end else begin
         sync_ready_out <= !(next_state == HBI_S_READY);
      end
   end

   // Async wait: low for the first clock of a strobe, single data
   logic [1:0] async_cnt;  // Clocks since strobe fell
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         async_cnt      <= 2'h0;
         async_wait_out <= 1'b1;
      end else begin
         if (!async_active) begin
            async_cnt      <= 2'h0;
            async_wait_out <= 1'b1;
         end else begin
            if (async_cnt != 2'(hbi_pkg::WAIT_CYCLES))
               async_cnt <= async_cnt + 2'h1;
            async_wait_out <= !(sel_any &&
               async_cnt < 2'(hbi_pkg::WAIT_CYCLES - 1));
         end
      end
   end

   // ------------------------------------------------------------
   // Access pulses toward the register core
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pulse     <= 1'b0;
         rd_pulse     <= 1'b0;
         reg_index    <= '0;
         data_reg_hit <= 1'b0;
         access_width <= hbi_pkg::HBI_W_NONE;
         wdata_out    <= '0;
      end else begin
         // Async write data taken at the strobe's rising edge
         wr_pulse <= (!wr_q && async_write_strobe && sel_any) ||
                     (state == HBI_S_READY && next_state == HBI_S_IDLE
                      && sync_wr);
         rd_pulse <= (!rd_q && async_read_strobe && sel_any) ||
                     (state == HBI_S_READY && next_state == HBI_S_IDLE
                      && !sync_wr);
         // Central select reaches only the data register
         reg_index    <= !data_reg_select ? hbi_pkg::DATA_REG_IDX
                         : cap.addr[hbi_pkg::REG_W-1:0];
         data_reg_hit <= !data_reg_select ||
                         cap.addr[hbi_pkg::REG_W-1:0] ==
                         hbi_pkg::DATA_REG_IDX;
         access_width <= dec_width;
         if (!async_write_strobe || sync_start) wdata_out <= wdata_in;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_ready_given;
      state == HBI_S_READY;
   endsequence

   a_hit_follows_decode: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      1 |=> local_hit_out == !($past(dec_hit) && $past(data_reg_select)))
      else $error("hit output does not follow decode");
   a_csel_forces_data: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      !data_reg_select |=> reg_index == hbi_pkg::DATA_REG_IDX
                           && access_width == hbi_pkg::HBI_W_32)
      else $error("central select did not force data access");
   a_sync_ready_wait: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (state == HBI_S_IDLE && sync_start) |=> ##[1:3] !sync_ready_out)
      else $error("sync ready not given in time");
   a_single_holds_ready: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (s_ready_given and !sync_flavour_select && ready_return_in)
      |=> state == HBI_S_READY)
      else $error("single cycle ended without ready return");
   a_async_wait_low: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      ($fell(async_read_strobe) && sel_any && async_write_strobe)
      |=> !async_wait_out)
      else $error("async wait not inserted");
   a_write_on_rise: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      ($rose(async_write_strobe) && sel_any && state == HBI_S_IDLE)
      |=> wr_pulse)
      else $error("write strobe rise did not write");
   a_lane_width: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (data_reg_select && cap.lanes_n == hbi_pkg::LANES_B2)
      |=> access_width == hbi_pkg::HBI_W_B2)
      else $error("lane pattern decoded to wrong width");
   a_sample_direction: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (state == HBI_S_IDLE && sync_start && !sync_flavour_select)
      |=> sync_wr == $past(write_read_select))
      else $error("direction not sampled by cycle strobe");
endmodule

/* testbench/hbi_host_model.sv */
// Host model that answers the device's synchronous ready handshake
`timescale 1ns/1ps
module hbi_host_model (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // Device side
   input  wire logic       sync_ready_out,
   input  wire logic       sync_flavour_select,
   // Bench control: falling edges to wait before acknowledging
   input  wire logic [3:0] ack_delay,
   // Ready return toward the device
   output logic            ready_return_in
);
   // ------------------------------------------------------------
   // Ready return handshake
   // ------------------------------------------------------------
   // Falling-edge driver so the device always samples a settled level
   initial begin
      ready_return_in = 1'b1;
      forever begin
         @(negedge core_clk);
         // Burst mode: this host adds no waits, return stays high
         if (rst_n && !sync_flavour_select && sync_ready_out === 1'b0) begin
            repeat (ack_delay) @(negedge core_clk);
            ready_return_in = 1'b0;
            // Hold until the device has dropped its ready
            while (sync_ready_out !== 1'b1) @(negedge core_clk);
            ready_return_in = 1'b1;
         end
      end
   end
endmodule

/* testbench/hbi_bus_unit_tb_top.sv */
// Self-checking testbench for the host bus interface unit
`timescale 1ns/1ps
module hbi_bus_unit_tb_top;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic                   core_clk = 1'b0;  // 200 MHz bus clock
   logic                   rst_n;            // Async reset
   int                     bad_count = 0;    // Mismatches
   int                     compares = 0;     // Comparisons made
   int                     cycles = 0;       // Timeout counter
   logic [14:0]            addr;             // Address bits 15..1
   logic                   qual;             // Address qualifier
   logic [3:0]             lanes_n;          // Lane enables
   logic                   latch_n;          // Address latch strobe
   logic                   dsel_n;           // Data register select
   logic                   flavour;          // Sync flavour select
   logic                   cyc_n;            // Cycle strobe
   logic                   wrs;              // Write/read select
   logic                   ret_n;            // Ready return (model)
   logic                   rd_n;             // Async read strobe
   logic                   wr_n;             // Async write strobe
   logic [31:0]            wdata;            // Write data
   logic [3:0]             ack_delay;        // Model acknowledge delay
   logic                   hit_n;            // Device outputs follow
   logic                   rdy_n;
   logic                   wait_n;
   logic                   wr_pulse;
   logic                   rd_pulse;
   logic                   dreg_hit;
   logic [2:0]             reg_index;
   hbi_pkg::hbi_width_type access_width;
   logic [31:0]            wdata_out;

   hbi_bus_unit hbi_bus_unit_i (
      .core_clk(core_clk), .rst_n(rst_n), .addr_in(addr),
      .address_qualifier(qual), .lane0_enable(lanes_n[0]),
      .lane1_enable(lanes_n[1]), .lane2_enable(lanes_n[2]),
      .lane3_enable(lanes_n[3]), .address_latch_strobe(latch_n),
      .data_reg_select(dsel_n), .sync_flavour_select(flavour),
      .cycle_strobe(cyc_n), .write_read_select(wrs),
      .ready_return_in(ret_n), .async_read_strobe(rd_n),
      .async_write_strobe(wr_n), .wdata_in(wdata),
      .local_hit_out(hit_n), .sync_ready_out(rdy_n),
      .async_wait_out(wait_n), .wr_pulse(wr_pulse), .rd_pulse(rd_pulse),
      .reg_index(reg_index), .data_reg_hit(dreg_hit),
      .access_width(access_width), .wdata_out(wdata_out));

   hbi_host_model hbi_host_model_i (
      .core_clk(core_clk), .rst_n(rst_n), .sync_ready_out(rdy_n),
      .sync_flavour_select(flavour), .ack_delay(ack_delay),
      .ready_return_in(ret_n));

   // ------------------------------------------------------------
   // Clock and timeout
   // ------------------------------------------------------------
   always #2.5 core_clk = ~core_clk;
   // Whole run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         stop_test();
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic stop_test();
      $display("mismatches %0d, compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   // Sample just after a rising edge, once its updates have landed
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask

   // Hit output is registered, so allow two edges to settle
   task automatic set_addr(input logic q, input logic [14:0] a);
      @(negedge core_clk);
      qual = q;
      addr = a;
      repeat (2) tick();
   endtask

   // Single async transfer; sync inputs stay idle throughout
   task automatic async_xfer(input logic wr, input logic [2:0] idx,
                             input logic [31:0] d, input logic dreg,
                             input hbi_pkg::hbi_width_type w);
      int n;
      @(negedge core_clk);
      wdata = d;
      if (wr) wr_n = 1'b0; else rd_n = 1'b0;
      n = 0;
      while (wait_n !== 1'b0 && n < 4) begin tick(); n++; end
      chk(wait_n, 1'b0);
      n = 0;
      while (wait_n !== 1'b1 && n < 4) begin tick(); n++; end
      chk(wait_n, 1'b1);
      @(negedge core_clk);
      wr_n = 1'b1;
      rd_n = 1'b1;
      n = 0;
      while ((wr ? wr_pulse : rd_pulse) !== 1'b1 && n < 4) begin
         tick();
         n++;
      end
      chk(wr ? wr_pulse : rd_pulse, 1'b1);
      chk(reg_index, idx);
      chk(dreg_hit, dreg);
      chk(32'(access_width), 32'(w));
      if (wr) chk(wdata_out, d);
      tick();
      chk(wr ? wr_pulse : rd_pulse, 1'b0);
   endtask

   // Single sync cycle; the model acknowledges after d falling edges
   task automatic sync_single(input logic wr, input logic [3:0] d);
      int n;
      @(negedge core_clk);
      ack_delay = d;
      wrs = wr;
      cyc_n = 1'b0;
      @(negedge core_clk);
      cyc_n = 1'b1;
      n = 0;
      while (rdy_n !== 1'b0 && n < 8) begin tick(); n++; end
      chk(n, hbi_pkg::WAIT_CYCLES);
      n = 0;
      while (rdy_n !== 1'b1 && n < 20) begin @(negedge core_clk); n++; end
      chk(n, 32'(d) + 2);
      chk(wr ? wr_pulse : rd_pulse, 1'b1);
      chk(wr ? rd_pulse : wr_pulse, 1'b0);
      wrs = 1'b1;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_decode();
      set_addr(1'b1, {hbi_pkg::BASE_DEFAULT, 3'h7});
      chk(hit_n, 1'b0);
      set_addr(1'b1, {hbi_pkg::BASE_DEFAULT + 12'h001, 3'h0});
      chk(hit_n, 1'b1);
      set_addr(1'b0, {hbi_pkg::BASE_DEFAULT, 3'h0});
      chk(hit_n, 1'b1);
   endtask

   task automatic test_lanes();
      logic [3:0] pat [7];
      hbi_pkg::hbi_width_type wexp [7];
      pat = '{hbi_pkg::LANES_ALL, hbi_pkg::LANES_LOW, hbi_pkg::LANES_HIGH,
              hbi_pkg::LANES_B0, hbi_pkg::LANES_B1, hbi_pkg::LANES_B2,
              hbi_pkg::LANES_B3};
      wexp = '{hbi_pkg::HBI_W_32, hbi_pkg::HBI_W_LO16, hbi_pkg::HBI_W_HI16,
               hbi_pkg::HBI_W_B0, hbi_pkg::HBI_W_B1, hbi_pkg::HBI_W_B2,
               hbi_pkg::HBI_W_B3};
      set_addr(1'b1, {hbi_pkg::BASE_DEFAULT, 3'h2});
      chk(hit_n, 1'b0);
      for (int i = 0; i < 7; i++) begin
         @(negedge core_clk);
         lanes_n = pat[i];
         async_xfer(1'b1, 3'h2, 32'h5a00_0000 | i, 1'b0, wexp[i]);
      end
      async_xfer(1'b0, 3'h2, 32'h0, 1'b0, hbi_pkg::HBI_W_B3);
   endtask

   // Central select with a foreign address and an odd lane pattern
   task automatic test_data_select();
      set_addr(1'b1, 15'h0000);
      chk(hit_n, 1'b1);
      @(negedge core_clk);
      dsel_n = 1'b0;
      lanes_n = 4'ha;
      async_xfer(1'b1, hbi_pkg::DATA_REG_IDX, 32'hc0de_f00d, 1'b1,
                 hbi_pkg::HBI_W_32);
      @(negedge core_clk);
      dsel_n = 1'b1;
      lanes_n = hbi_pkg::LANES_ALL;
   endtask

   // Latched address must win over a changed live address
   task automatic test_latch();
      set_addr(1'b1, {hbi_pkg::BASE_DEFAULT, 3'h5});
      @(negedge core_clk);
      latch_n = 1'b1;
      @(negedge core_clk);
      addr = 15'h0000;
      qual = 1'b0;
      lanes_n = hbi_pkg::LANES_B3;
      repeat (2) tick();
      chk(hit_n, 1'b0);
      async_xfer(1'b1, 3'h5, 32'h0bad_cafe, 1'b0,
                 hbi_pkg::HBI_W_32);
      @(negedge core_clk);
      latch_n = 1'b0;
      lanes_n = hbi_pkg::LANES_ALL;
      repeat (2) tick();
      chk(hit_n, 1'b1);
   endtask

   task automatic test_burst(input logic wr);
      logic seen_rdy;
      logic seen_pulse;
      seen_rdy = 1'b0;
      seen_pulse = 1'b0;
      @(negedge core_clk);
      flavour = 1'b1;
      @(negedge core_clk);
      if (wr) cyc_n = 1'b0; else wrs = 1'b0;
      for (int i = 0; i < 12; i++) begin
         @(negedge core_clk);
         if (rdy_n === 1'b0) begin
            seen_rdy = 1'b1;
            cyc_n = 1'b1;
            wrs = 1'b1;
         end
         if ((wr ? wr_pulse : rd_pulse) === 1'b1) seen_pulse = 1'b1;
      end
      chk(seen_rdy, 1'b1);
      chk(seen_pulse, 1'b1);
      chk(rdy_n, 1'b1);
      flavour = 1'b0;
   endtask

   // Unqualified address: a sync start must be ignored
   task automatic test_unselected();
      logic moved;
      moved = 1'b0;
      set_addr(1'b0, {hbi_pkg::BASE_DEFAULT, 3'h1});
      @(negedge core_clk);
      cyc_n = 1'b0;
      @(negedge core_clk);
      cyc_n = 1'b1;
      repeat (6) begin
         tick();
         if (rdy_n !== 1'b1 || wr_pulse !== 1'b0) moved = 1'b1;
      end
      chk(moved, 1'b0);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      {addr, qual, lanes_n, latch_n, dsel_n} = {15'h0, 1'b0, 4'h0, 2'b01};
      {flavour, cyc_n, wrs, rd_n, wr_n} = 5'b01111;
      wdata = 32'h0;
      ack_delay = 4'h0;
      repeat (5) tick();
      chk({hit_n, rdy_n, wait_n, wr_pulse, rd_pulse}, 5'h1c);
      chk(32'(access_width), 32'(hbi_pkg::HBI_W_NONE));
      @(negedge core_clk);
      rst_n = 1'b1;
      test_decode();
      test_lanes();
      test_data_select();
      test_latch();
      set_addr(1'b1, {hbi_pkg::BASE_DEFAULT, 3'h1});
      sync_single(1'b1, 4'h0);
      sync_single(1'b0, 4'h3);
      sync_single(1'b1, 4'h3);
      test_burst(1'b1);
      test_burst(1'b0);
      test_unselected();
      stop_test();
   end
endmodule
